/* File: design/ioj_exec.sv */
// Executor for increment, increment-skip, jump and the two OR instructions
`timescale 1ns/10ps
`include "ioj_regs.svh"
module ioj_exec (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] program_counter_high_latch,
    output logic instr_accept,
    output logic [12:0] pc_out,
    output logic [7:0] acc_out,
    output logic null_flag,
    output logic file_we,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    ioj_pkg::ioj_state_type state_reg, state_next;
    ioj_pkg::ioj_pc_type pc_reg, pc_next;
    ioj_pkg::ioj_byte_type acc_reg, acc_next;
    logic null_reg, null_next;
    logic we_reg, we_next;
    logic [6:0] waddr_reg;
    ioj_pkg::ioj_byte_type wdata_reg, wdata_next;
    logic accept_reg;

    function automatic logic op6_is(input logic [13:0] w, input logic [5:0] op);
        op6_is = (w[13:`IOJ_OP6_LSB] == op);
    endfunction

    wire take = instr_valid && (state_reg == ioj_pkg::IOJ_RUN);
    wire squash = instr_valid && (state_reg == ioj_pkg::IOJ_SQUASH);
    wire is_inc_skip = take && op6_is(instr_word, `IOJ_OP_INC_SKIP);
    wire is_inc = take && op6_is(instr_word, `IOJ_OP_INC);
    wire is_or_reg = take && op6_is(instr_word, `IOJ_OP_OR_REG);
    wire is_or_lit = take && (instr_word[13:`IOJ_OP4_LSB] == `IOJ_OP_OR_LIT);
    wire is_jump = take && (instr_word[13:`IOJ_OP3_LSB] == `IOJ_OP_JUMP);
    wire dest_file = instr_word[`IOJ_DEST_BIT];
    wire [6:0] faddr = instr_word[`IOJ_FADDR_MSB:0];
    wire [7:0] literal = instr_word[`IOJ_LIT_MSB:0];
    // Increment wraps modulo 256 by width
    wire [7:0] inc_sum = 8'(file_rdata + 8'h01);
    wire [7:0] or_reg_val = acc_reg | file_rdata;
    wire [7:0] or_lit_val = acc_reg | literal;
    wire routed = is_inc_skip || is_inc || is_or_reg;
    wire [7:0] routed_val = is_or_reg ? or_reg_val : inc_sum;
    wire [12:0] jump_target = {program_counter_high_latch[`IOJ_LATCH_PAGE_MSB:`IOJ_LATCH_PAGE_LSB],
                               instr_word[`IOJ_JUMP_MSB:0]};
    wire [12:0] pc_inc = 13'(pc_reg + 13'h0001);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_next = ioj_pkg::IOJ_RUN;
        pc_next = pc_reg;
        acc_next = acc_reg;
        null_next = null_reg;
        we_next = 1'b0;
        wdata_next = wdata_reg;
        case (state_reg)
            ioj_pkg::IOJ_RUN: begin
                if (take) begin
                    pc_next = pc_inc;
                end
                if (routed && !dest_file) begin
                    acc_next = routed_val;
                end
                if (routed && dest_file) begin
                    we_next = 1'b1;
                    wdata_next = routed_val;
                end
                if (is_inc || is_or_reg) begin
                    null_next = (routed_val == 8'h00);
                end
                if (is_or_lit) begin
                    acc_next = or_lit_val;
                    null_next = (or_lit_val == 8'h00);
                end
                // Nonzero sum falls through and stays in RUN
                if (is_inc_skip && inc_sum == 8'h00) begin
                    state_next = ioj_pkg::IOJ_SQUASH;
                end
                if (is_jump) begin
                    // Flags untouched; second cycle refills from the new address
                    pc_next = jump_target;
                    state_next = ioj_pkg::IOJ_REFILL;
                end
            end
            ioj_pkg::IOJ_SQUASH: begin
                // Waits for the skipped word, which then executes as no-operation
                if (squash) begin
                    pc_next = pc_inc;
                end else begin
                    state_next = ioj_pkg::IOJ_SQUASH;
                end
            end
            ioj_pkg::IOJ_REFILL: begin
                state_next = ioj_pkg::IOJ_RUN;
            end
            default: begin
                state_next = ioj_pkg::IOJ_RUN;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ioj_pkg::IOJ_RUN;
            pc_reg <= `IOJ_PC_RST;
            acc_reg <= `IOJ_ACC_RST;
            null_reg <= `IOJ_ZERO_RST;
            we_reg <= 1'b0;
            waddr_reg <= 7'h00;
            wdata_reg <= 8'h00;
            accept_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            acc_reg <= acc_next;
            null_reg <= null_next;
            we_reg <= we_next;
            waddr_reg <= faddr;
            wdata_reg <= wdata_next;
            accept_reg <= (state_next != ioj_pkg::IOJ_REFILL);
        end
    end

    assign instr_accept = accept_reg;
    assign pc_out = pc_reg;
    assign acc_out = acc_reg;
    assign null_flag = null_reg;
    assign file_we = we_reg;
    assign file_waddr = waddr_reg;
    assign file_wdata = wdata_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_dest_file;
        @(posedge clk) disable iff (sys_rst)
        (is_inc || is_or_reg || is_inc_skip) && dest_file |=> file_we && file_wdata == $past(routed_val)
            && file_waddr == $past(faddr) && acc_out == $past(acc_reg);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination not written");

    property p_skip_flags;
        @(posedge clk) disable iff (sys_rst)
        is_inc_skip |=> null_flag == $past(null_reg);
    endproperty
    a_skip_flags: assert property (p_skip_flags) else $error("increment-skip changed the flag");

    property p_skip_squash;
        @(posedge clk) disable iff (sys_rst)
        is_inc_skip && inc_sum == 8'h00 ##1 instr_valid |=> !file_we && $stable(acc_out) && $stable(null_flag)
            && pc_out == 13'($past(pc_out) + 13'h0001);
    endproperty
    a_skip_squash: assert property (p_skip_squash) else $error("skipped word was executed");

    property p_skip_none;
        @(posedge clk) disable iff (sys_rst)
        is_inc_skip && inc_sum != 8'h00 |=> state_reg == ioj_pkg::IOJ_RUN && instr_accept;
    endproperty
    a_skip_none: assert property (p_skip_none) else $error("nonzero result caused a skip");

    property p_jump_target;
        @(posedge clk) disable iff (sys_rst)
        is_jump |=> pc_out[10:0] == $past(instr_word[10:0])
            && pc_out[12:11] == $past(program_counter_high_latch[4:3]);
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

    property p_jump_two;
        @(posedge clk) disable iff (sys_rst)
        is_jump |=> !instr_accept && $stable(null_flag) ##1 instr_accept && $stable(pc_out);
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

    property p_or_lit;
        @(posedge clk) disable iff (sys_rst)
        is_or_lit |=> acc_out == ($past(acc_reg) | $past(literal)) && null_flag == (acc_out == 8'h00);
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("literal OR wrong");

    property p_inc_flag;
        @(posedge clk) disable iff (sys_rst)
        is_inc && !dest_file |=> acc_out == 8'($past(file_rdata) + 8'h01) && null_flag == (acc_out == 8'h00);
    endproperty
    a_inc_flag: assert property (p_inc_flag) else $error("increment wrong");

    property p_or_reg;
        @(posedge clk) disable iff (sys_rst)
        is_or_reg |=> null_flag == (($past(acc_reg) | $past(file_rdata)) == 8'h00);
    endproperty
    a_or_reg: assert property (p_or_reg) else $error("register OR flag wrong");

    c_skip: cover property (@(posedge clk) disable iff (sys_rst) is_inc_skip && inc_sum == 8'h00 ##1 squash);
    c_jump: cover property (@(posedge clk) disable iff (sys_rst) is_jump ##2 take);
    c_or_file: cover property (@(posedge clk) disable iff (sys_rst) is_or_reg && dest_file);
    c_wrap: cover property (@(posedge clk) disable iff (sys_rst) is_inc && file_rdata == 8'hFF);

endmodule // ioj_exec

/* File: shared/ioj_pkg.sv */
// Types shared by the instruction executor
package ioj_pkg;

    typedef enum logic [1:0] {
        IOJ_RUN,
        IOJ_SQUASH,
        IOJ_REFILL
    } ioj_state_type;

    typedef logic [12:0] ioj_pc_type;
    typedef logic [7:0] ioj_byte_type;

endpackage

/* File: shared/ioj_regs.svh */
// Opcode encodings, field positions and reset values for the instruction executor
`ifndef IOJ_REGS_SVH
`define IOJ_REGS_SVH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define IOJ_INSTR_W 14
`define IOJ_DEST_BIT 7
`define IOJ_FADDR_MSB 6
`define IOJ_LIT_MSB 7
`define IOJ_JUMP_MSB 10
`define IOJ_OP6_LSB 8
`define IOJ_OP3_LSB 11
`define IOJ_OP4_LSB 10

// ----------------------------------------
// Opcode values
// ----------------------------------------
`define IOJ_OP_INC_SKIP 6'h0F
`define IOJ_OP_INC 6'h0A
`define IOJ_OP_OR_REG 6'h04
`define IOJ_OP_OR_LIT 4'hE
`define IOJ_OP_JUMP 3'h5

// ----------------------------------------
// Latch page bits and reset values
// ----------------------------------------
`define IOJ_LATCH_PAGE_MSB 4
`define IOJ_LATCH_PAGE_LSB 3
`define IOJ_PC_RST 13'h0000
`define IOJ_ACC_RST 8'h00
`define IOJ_ZERO_RST 1'b0

`endif

/* File: verif/testbench.sv */
// Self-checking testbench for the instruction executor
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------
    // Stimulus rows
    // ----------------------------------------
    typedef struct packed {
        logic [13:0] word;
        logic [7:0] rd;
        logic [7:0] lat;
        logic [12:0] pc;
        logic [7:0] acc;
        logic nul;
        logic we;
        logic [7:0] wd;
    } ioj_row_type;
    // Accumulator and flag carry over from row to row, so order matters
    ioj_row_type rows [0:11] = '{
        '{14'h3800, 8'h00, 8'h00, 13'h0001, 8'h00, 1'b1, 1'b0, 8'h00},
        '{14'h385A, 8'h00, 8'h00, 13'h0002, 8'h5A, 1'b0, 1'b0, 8'h00},
        '{14'h0A11, 8'hFF, 8'h00, 13'h0003, 8'h00, 1'b1, 1'b0, 8'h00},
        '{14'h0F90, 8'h7F, 8'h00, 13'h0004, 8'h00, 1'b1, 1'b1, 8'h80},
        '{14'h3801, 8'h00, 8'h00, 13'h0005, 8'h01, 1'b0, 1'b0, 8'h00},
        '{14'h0AFF, 8'h3C, 8'h00, 13'h0006, 8'h01, 1'b0, 1'b1, 8'h3D},
        '{14'h0422, 8'hA4, 8'h00, 13'h0007, 8'hA5, 1'b0, 1'b0, 8'h00},
        '{14'h0485, 8'h42, 8'h00, 13'h0008, 8'hA5, 1'b0, 1'b1, 8'hE7},
        '{14'h2FFF, 8'h00, 8'h18, 13'h1FFF, 8'hA5, 1'b0, 1'b0, 8'h00},
        '{14'h2800, 8'h00, 8'hE7, 13'h0000, 8'hA5, 1'b0, 1'b0, 8'h00},
        '{14'h2AAA, 8'h00, 8'h08, 13'h0AAA, 8'hA5, 1'b0, 1'b0, 8'h00},
        '{14'h38FF, 8'h00, 8'h00, 13'h0AAB, 8'hFF, 1'b0, 1'b0, 8'h00}};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic [7:0] file_rdata = 8'h00;
    logic [7:0] program_counter_high_latch = 8'h00;
    logic instr_accept;
    logic [12:0] pc_out;
    logic [7:0] acc_out;
    logic null_flag;
    logic file_we;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata;
    int err_total = 0;
    int num_checks = 0;

    ioj_exec u_ioj_exec (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
        .file_rdata(file_rdata), .program_counter_high_latch(program_counter_high_latch),
        .instr_accept(instr_accept), .pc_out(pc_out), .acc_out(acc_out), .null_flag(null_flag),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata));

    always #2 clk = ~clk;

    // ----------------------------------------
    // Compare and closing tasks
    // ----------------------------------------
    task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Offer one word, let the taking edge pass, look just after it
    task automatic send(input logic [13:0] w, input logic [7:0] d, input logic [7:0] lat);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        file_rdata <= d;
        program_counter_high_latch <= lat;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    initial begin
        // Initialised reset level makes no edge, so look after the first clock
        @(posedge clk);
        #1;
        chk_pc(pc_out, 13'h0000);
        chk_byte(acc_out, 8'h00);
        chk_bit(null_flag, 1'b0);
        chk_bit(file_we, 1'b0);
        repeat (19) @(posedge clk);
        sys_rst <= 1'b0;
        chk_bit(instr_accept, 1'b1);
        foreach (rows[i]) begin
            send(rows[i].word, rows[i].rd, rows[i].lat);
            chk_pc(pc_out, rows[i].pc);
            chk_byte(acc_out, rows[i].acc);
            chk_bit(null_flag, rows[i].nul);
            chk_bit(file_we, rows[i].we);
            if (rows[i].we) begin
                chk_byte(file_wdata, rows[i].wd);
                chk_byte({1'b0, file_waddr}, {1'b0, rows[i].word[6:0]});
            end
        end
        // Zero skip result squashes the following word
        send(14'h0F7F, 8'hFF, 8'h00);
        chk_byte(acc_out, 8'h00);
        chk_bit(null_flag, 1'b0);
        send(14'h3801, 8'h00, 8'h00);
        chk_byte(acc_out, 8'h00);
        chk_pc(pc_out, 13'h0AAD);
        send(14'h3800, 8'h00, 8'h00);
        chk_bit(null_flag, 1'b1);
        // Word held through the dead cycle after a jump is ignored there
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= 14'h2923;
        program_counter_high_latch <= 8'h10;
        @(posedge clk);
        instr_word <= 14'h380F;
        #1;
        chk_bit(instr_accept, 1'b0);
        chk_pc(pc_out, 13'h1123);
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk_byte(acc_out, 8'h00);
        chk_bit(null_flag, 1'b1);
        chk_pc(pc_out, 13'h1123);
        chk_bit(instr_accept, 1'b1);
        // Zero skip result with the next word right behind it
        send(14'h3801, 8'h00, 8'h00);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= 14'h0FFF;
        file_rdata <= 8'hFF;
        @(posedge clk);
        instr_word <= 14'h38F0;
        #1;
        chk_bit(file_we, 1'b1);
        chk_byte(file_wdata, 8'h00);
        chk_bit(null_flag, 1'b0);
        chk_pc(pc_out, 13'h1125);
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk_byte(acc_out, 8'h01);
        chk_pc(pc_out, 13'h1126);
        chk_bit(file_we, 1'b0);
        // Reset in mid-run while a skip is pending, then run again
        send(14'h0FFF, 8'hFF, 8'h00);
        @(posedge clk);
        sys_rst <= 1'b1;
        #1;
        chk_pc(pc_out, 13'h0000);
        chk_byte(acc_out, 8'h00);
        chk_bit(null_flag, 1'b0);
        chk_bit(file_we, 1'b0);
        chk_bit(instr_accept, 1'b1);
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        send(14'h0A8F, 8'hFF, 8'h00);
        chk_pc(pc_out, 13'h0001);
        chk_bit(file_we, 1'b1);
        chk_byte({1'b0, file_waddr}, 8'h0F);
        chk_byte(file_wdata, 8'h00);
        chk_bit(null_flag, 1'b1);
        chk_byte(acc_out, 8'h00);
        // Word outside the five only moves the counter
        send(14'h0000, 8'h00, 8'h00);
        chk_pc(pc_out, 13'h0002);
        chk_bit(null_flag, 1'b1);
        chk_bit(file_we, 1'b0);
        stop_test();
    end

    initial begin
        #2000;
        err_total++;
        stop_test();
    end
endmodule // testbench
